// ==== dfs_defs.svh ====
// register map, field positions and counts for the ds3 frame sync block
`ifndef DFS_DEFS_SVH
`define DFS_DEFS_SVH
`define DFS_IDX_TST  6'h0C
`define DFS_IDX_CS   6'h10
`define DFS_IDX_ST   6'h11
`define DFS_IDX_IEN  6'h12
`define DFS_IDX_IST  6'h13
`define DFS_B_CHK    3
`define DFS_B_GEN    2
`define DFS_B_AIS    7
`define DFS_B_LOS    6
`define DFS_B_IDLE   5
`define DFS_B_OOF    4
`define DFS_B_PAR    2
`define DFS_B_FSEL   1
`define DFS_B_MSEL   0
`define DFS_B_FERF   4
`define DFS_B_AIC    3
`define DFS_F_FEBE   2:0
`define DFS_I_CP     7
`define DFS_I_LOS    6
`define DFS_I_AIS    5
`define DFS_I_IDLE   4
`define DFS_I_FERF   3
`define DFS_I_AIC    2
`define DFS_I_OOF    1
`define DFS_I_PERR   0
`define DFS_WCW      5
`define DFS_FWIN     16
`define DFS_FTHR_1   5'h03
`define DFS_FTHR_0   5'h06
`define DFS_MWIN     4
`define DFS_MTHR     5'h03
`define DFS_PWIN     5
`define DFS_PTHR     5'h02
`define DFS_AWIN     15
`define DFS_ATHR     5'h02
`define DFS_AIC_RUN  6'h3F
`define DFS_LOS_ZERO 180
`define DFS_LOS_MARK 60
`endif

// ==== dfs_err_window.sv ====
// m-of-n sliding error window over the last n events
`timescale 1ns/100ps
module dfs_err_window #(
  parameter int N  = 16,
  parameter int CW = 5
) (
  input logic   clk_i,
  input logic   rst_b_i,
  dfs_win_if.win w
);
  logic [N-1:0]  hist;
  logic [CW-1:0] cnt;

  if (N < 2 || N >= 2 ** CW || CW != 5) begin : g_bad
    $error("window size does not fit counter");
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i || w.clr) begin
      hist <= '0;
      cnt  <= '0;
    end else if (w.ev) begin
      hist <= {hist[N-2:0], w.err};
      cnt  <= cnt + CW'(w.err) - CW'(hist[N-1]);
    end
  end

  assign w.hit = (cnt >= w.thr);

  win_bound_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cnt <= CW'(N)) else $error("window count above window size");
endmodule

// ==== dfs_liu_model.sv ====
// line side model feeding received bits and m-frame overhead
`timescale 1ns/100ps
module dfs_liu_model (
  input  logic       clk_i,
  output logic       bit_en_o,
  output logic       bit_o,
  output logic       mf_en_o,
  output logic       aic_o,
  output logic [2:0] febe_o
);
  initial begin
    bit_en_o = 1'b0;
    bit_o = 1'b0;
    mf_en_o = 1'b0;
    aic_o = 1'b0;
    febe_o = 3'h0;
  end
  // idle lines show the inverse of the last value, never a held copy
  task automatic send_bits(input int n, input logic v);
    repeat (n) begin
      @(posedge clk_i);
      bit_en_o <= 1'b1;
      bit_o <= v;
    end
    @(posedge clk_i);
    bit_en_o <= 1'b0;
    bit_o <= ~v;
  endtask
  task automatic send_frames(input int n, input logic a, input logic [2:0] f);
    repeat (n) begin
      @(posedge clk_i);
      mf_en_o <= 1'b1;
      aic_o <= a;
      febe_o <= f;
    end
    @(posedge clk_i);
    mf_en_o <= 1'b0;
    aic_o <= ~a;
    febe_o <= ~f;
  endtask
endmodule

// ==== dfs_los_detect.sv ====
// loss of signal detector on the received bit stream
`timescale 1ns/100ps
module dfs_los_detect #(
  parameter int WIN   = 180,
  parameter int MARKS = 60,
  parameter int CW    = 8
) (
  input  logic clk_i,
  input  logic rst_b_i,
  input  logic bit_en_i,
  input  logic bit_i,
  output logic los_o
);
  logic [WIN-1:0] hist;
  logic [CW-1:0]  marks;
  logic [CW-1:0]  next_marks;
  logic [CW-1:0]  zrun;

  if (MARKS > WIN || WIN >= 2 ** CW) begin : g_bad
    $error("los window does not fit counter");
  end

  assign next_marks = marks + CW'(bit_i) - CW'(hist[WIN-1]);

  // marks in the last WIN bit periods
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hist  <= '0;
      marks <= '0;
    end else if (bit_en_i) begin
      hist  <= {hist[WIN-2:0], bit_i};
      marks <= next_marks;
    end
  end

  // run of zeros, saturating so a long outage cannot wrap
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) zrun <= '0;
    else if (bit_en_i) begin
      if (bit_i) zrun <= '0;
      else if (zrun != CW'(WIN)) zrun <= zrun + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) los_o <= 1'b0;
    else if (bit_en_i) begin
      if (!bit_i && zrun == CW'(WIN - 1)) los_o <= 1'b1;
      else if (los_o && next_marks >= CW'(MARKS)) los_o <= 1'b0;
    end
  end

  los_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(los_o) |-> $past(zrun) == CW'(WIN - 1)) else $error("los set early");
  los_clr_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(los_o) |-> marks >= CW'(MARKS)) else $error("los cleared early");
endmodule

// ==== dfs_pkg.sv ====
// types shared by the ds3 frame sync block
package dfs_pkg;
  typedef enum logic {DFS_SEARCH, DFS_INFRAME} dfs_state_t;
endpackage

// ==== dfs_rx_frame_sync.sv ====
// ds3 receive frame sync, alarm status and register block
//
// Design decision made here: the Wishbone interface to the registers.
`timescale 1ns/100ps
// Overview of operation
// - checker enable bit switches pattern checker
// - generator enable bit switches pattern generator
// - bit 7 shows alarm pattern reception
// - bit 6 shows loss of signal
// - bit 5 shows idle pattern, ds3 only
// - bit 4 shows out of frame
// - parity option adds p-bit check to acquisition
// - parity option: 2 of 5 errors reframe
// - f-bit threshold 3 or 6 of 16
// - m-bit option: 3 of 4 errors reframe
// - m-bit option off ignores m errors
// - status bit 4 shows far-end failure
// - format flag sets after 63 ones
// - format flag clears on 2 of 15 zeros
// - febe field holds latest frame code
// - los: 180 zeros set, 60 marks clear
`include "dfs_defs.svh"
module dfs_rx_frame_sync (
  input  logic        clk_i,
  input  logic        rst_b_i,
  input  logic        wb_cyc_i,
  input  logic        wb_stb_i,
  input  logic        wb_we_i,
  input  logic [7:0]  wb_adr_i,
  input  logic [3:0]  wb_sel_i,
  input  logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic        wb_ack_o,
  output logic        irq_o,
  input  logic        rx_bit_en_i,
  input  logic        rx_bit_i,
  input  logic        ais_det_i,
  input  logic        idle_det_i,
  input  logic        ferf_det_i,
  input  logic        frame_cand_i,
  input  logic        parity_ok_i,
  input  logic        fbit_en_i,
  input  logic        fbit_err_i,
  input  logic        mbit_en_i,
  input  logic        mbit_err_i,
  input  logic        pbit_en_i,
  input  logic        pbit_err_i,
  input  logic        cbit_err_i,
  input  logic        mframe_en_i,
  input  logic        aic_bit_i,
  input  logic [2:0]  febe_i,
  output logic        pattern_checker_en_o,
  output logic        pattern_generator_en_o,
  output logic        out_of_frame_o,
  output logic        reframe_o
);

  dfs_pkg::dfs_state_t state;
  dfs_pkg::dfs_state_t next_state;

  logic       req;
  logic       wr;
  logic [5:0] idx;
  logic [7:0] next_rdata;
  logic       par_en;
  logic       fbit_threshold_sel;
  logic       mbit_check_sel;
  logic       alarm_pattern_flag;
  logic       signal_loss_flag;
  logic       idle_pattern_flag;
  logic       far_end_fail_flag;
  logic       format_ident_flag;
  logic [2:0] far_end_block_err_code;
  logic [5:0] aic_run;
  logic       lost;
  logic [7:0] flags_q;
  logic [7:0] flags;
  logic [7:0] ev;
  logic [7:0] int_stat;
  logic [7:0] int_mask;
  logic [7:0] w1c;

  dfs_win_if f_if ();
  dfs_win_if m_if ();
  dfs_win_if p_if ();
  dfs_win_if a_if ();

  // ---- register bus ----
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr  = req & wb_we_i & wb_sel_i[0];
  assign idx = wb_adr_i[7:2];

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) wb_ack_o <= 1'b0;
    else wb_ack_o <= req;
  end

  // reads only select, nothing is cleared by them
  always_comb begin
    next_rdata = 8'h00;
    case (idx)
      `DFS_IDX_TST: begin
        next_rdata[`DFS_B_CHK] = pattern_checker_en_o;
        next_rdata[`DFS_B_GEN] = pattern_generator_en_o;
      end
      `DFS_IDX_CS: begin
        next_rdata[`DFS_B_AIS]  = alarm_pattern_flag;
        next_rdata[`DFS_B_LOS]  = signal_loss_flag;
        next_rdata[`DFS_B_IDLE] = idle_pattern_flag;
        next_rdata[`DFS_B_OOF]  = out_of_frame_o;
        next_rdata[`DFS_B_PAR]  = par_en;
        next_rdata[`DFS_B_FSEL] = fbit_threshold_sel;
        next_rdata[`DFS_B_MSEL] = mbit_check_sel;
      end
      `DFS_IDX_ST: begin
        next_rdata[`DFS_B_FERF] = far_end_fail_flag;
        next_rdata[`DFS_B_AIC]  = format_ident_flag;
        next_rdata[`DFS_F_FEBE] = far_end_block_err_code;
      end
      `DFS_IDX_IEN: next_rdata = int_mask;
      `DFS_IDX_IST: next_rdata = int_stat;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) wb_dat_o <= 32'h0000_0000;
    else if (req) wb_dat_o <= {24'h00_0000, next_rdata};
  end

  // ---- configuration ----
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      par_en             <= 1'b0;
      fbit_threshold_sel <= 1'b0;
      mbit_check_sel     <= 1'b0;
    end else if (wr && idx == `DFS_IDX_CS) begin
      par_en             <= wb_dat_i[`DFS_B_PAR];
      fbit_threshold_sel <= wb_dat_i[`DFS_B_FSEL];
      mbit_check_sel     <= wb_dat_i[`DFS_B_MSEL];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pattern_checker_en_o   <= 1'b0;
      pattern_generator_en_o <= 1'b0;
    end else if (wr && idx == `DFS_IDX_TST) begin
      pattern_checker_en_o   <= wb_dat_i[`DFS_B_CHK];
      pattern_generator_en_o <= wb_dat_i[`DFS_B_GEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) int_mask <= 8'h00;
    else if (wr && idx == `DFS_IDX_IEN) int_mask <= wb_dat_i[7:0];
  end

  // ---- live alarm indicators ----
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      alarm_pattern_flag <= 1'b0;
      idle_pattern_flag  <= 1'b0;
      far_end_fail_flag  <= 1'b0;
    end else begin
      alarm_pattern_flag <= ais_det_i;
      idle_pattern_flag  <= idle_det_i;
      far_end_fail_flag  <= ferf_det_i;
    end
  end

  dfs_los_detect #(
    .WIN   (`DFS_LOS_ZERO),
    .MARKS (`DFS_LOS_MARK),
    .CW    (8)
  ) u_los (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .bit_en_i (rx_bit_en_i),
    .bit_i    (rx_bit_i),
    .los_o    (signal_loss_flag)
  );

  // ---- frame maintenance windows ----
  // windows are cleared while searching so a fresh lock starts clean
  assign f_if.ev  = fbit_en_i & ~out_of_frame_o;
  assign f_if.err = fbit_err_i;
  assign f_if.clr = out_of_frame_o;
  assign f_if.thr = fbit_threshold_sel ? `DFS_FTHR_1 : `DFS_FTHR_0;

  assign m_if.ev  = mbit_en_i & ~out_of_frame_o;
  assign m_if.err = mbit_err_i & mbit_check_sel;
  assign m_if.clr = out_of_frame_o;
  assign m_if.thr = `DFS_MTHR;

  assign p_if.ev  = pbit_en_i & ~out_of_frame_o;
  assign p_if.err = pbit_err_i;
  assign p_if.clr = out_of_frame_o;
  assign p_if.thr = `DFS_PTHR;

  dfs_err_window #(.N(`DFS_FWIN), .CW(`DFS_WCW)) u_fwin (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .w       (f_if)
  );
  dfs_err_window #(.N(`DFS_MWIN), .CW(`DFS_WCW)) u_mwin (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .w       (m_if)
  );
  dfs_err_window #(.N(`DFS_PWIN), .CW(`DFS_WCW)) u_pwin (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .w       (p_if)
  );

  assign lost = f_if.hit
              | (mbit_check_sel & m_if.hit)
              | (par_en & p_if.hit);

  always_comb begin
    next_state = state;
    case (state)
      dfs_pkg::DFS_SEARCH:
        if (frame_cand_i && (!par_en || parity_ok_i)) next_state = dfs_pkg::DFS_INFRAME;
      dfs_pkg::DFS_INFRAME:
        if (lost) next_state = dfs_pkg::DFS_SEARCH;
      default: next_state = dfs_pkg::DFS_SEARCH;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) state <= dfs_pkg::DFS_SEARCH;
    else state <= next_state;
  end

  // a framer starts out of frame, so reset shows search with the flag cleared
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) out_of_frame_o <= 1'b0;
    else out_of_frame_o <= (next_state == dfs_pkg::DFS_SEARCH);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) reframe_o <= 1'b0;
    else reframe_o <= (state == dfs_pkg::DFS_INFRAME) && lost;
  end

  // ---- c-bit format identification ----
  assign a_if.ev  = mframe_en_i;
  assign a_if.err = ~aic_bit_i;
  assign a_if.clr = 1'b0;
  assign a_if.thr = `DFS_ATHR;

  dfs_err_window #(.N(`DFS_AWIN), .CW(`DFS_WCW)) u_awin (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .w       (a_if)
  );

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) aic_run <= 6'h00;
    else if (mframe_en_i) begin
      if (!aic_bit_i) aic_run <= 6'h00;
      else if (aic_run != `DFS_AIC_RUN) aic_run <= aic_run + 6'h01;
    end
  end

  // a full run of ones implies no zero in the window, so set and clear never meet
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) format_ident_flag <= 1'b0;
    else if (mframe_en_i && aic_bit_i && aic_run == `DFS_AIC_RUN - 6'h01)
      format_ident_flag <= 1'b1;
    else if (a_if.hit) format_ident_flag <= 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) far_end_block_err_code <= 3'h0;
    else if (mframe_en_i) far_end_block_err_code <= febe_i;
  end

  // ---- interrupts: change of state events, plus c-bit and p-bit error events ----
  always_comb begin
    flags = 8'h00;
    flags[`DFS_I_LOS]  = signal_loss_flag;
    flags[`DFS_I_AIS]  = alarm_pattern_flag;
    flags[`DFS_I_IDLE] = idle_pattern_flag;
    flags[`DFS_I_FERF] = far_end_fail_flag;
    flags[`DFS_I_AIC]  = format_ident_flag;
    flags[`DFS_I_OOF]  = out_of_frame_o;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) flags_q <= 8'h00;
    else flags_q <= flags;
  end

  always_comb begin
    ev = flags ^ flags_q;
    ev[`DFS_I_CP]   = cbit_err_i;
    ev[`DFS_I_PERR] = pbit_en_i & pbit_err_i;
  end

  assign w1c = (wr && idx == `DFS_IDX_IST) ? wb_dat_i[7:0] : 8'h00;

  // set wins over a clear in the same cycle
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) int_stat <= 8'h00;
    else int_stat <= (int_stat & ~w1c) | ev;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) irq_o <= 1'b0;
    else irq_o <= |(int_stat & int_mask);
  end

  // ---- checks ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_wr_tst;
    wr && idx == `DFS_IDX_TST;
  endsequence
  sequence s_rd_cs;
    req && !wb_we_i && idx == `DFS_IDX_CS;
  endsequence
  sequence s_rd_st;
    req && !wb_we_i && idx == `DFS_IDX_ST;
  endsequence

  chk_enable_a: assert property (
    s_wr_tst |=> pattern_checker_en_o == $past(wb_dat_i[`DFS_B_CHK]))
    else $error("checker enable not taken");
  gen_enable_a: assert property (
    s_wr_tst |=> pattern_generator_en_o == $past(wb_dat_i[`DFS_B_GEN]))
    else $error("generator enable not taken");
  ais_read_a: assert property (
    ais_det_i ##1 s_rd_cs |=> wb_dat_o[`DFS_B_AIS])
    else $error("alarm pattern not reported");
  los_read_a: assert property (
    s_rd_cs |=> wb_dat_o[`DFS_B_LOS] == $past(signal_loss_flag))
    else $error("loss of signal misreported");
  oof_read_a: assert property (
    s_rd_cs |=> wb_dat_o[`DFS_B_OOF] == $past(out_of_frame_o) && wb_ack_o)
    else $error("out of frame misreported");
  par_acq_a: assert property (
    state == dfs_pkg::DFS_SEARCH && par_en && !parity_ok_i |=> out_of_frame_o)
    else $error("in frame without parity");
  lost_frame_a: assert property (
    state == dfs_pkg::DFS_INFRAME && f_if.hit |=> out_of_frame_o && reframe_o)
    else $error("f-bit errors did not reframe");
  mbit_ignore_a: assert property (
    state == dfs_pkg::DFS_INFRAME && !mbit_check_sel && !f_if.hit && !p_if.hit
    |=> !out_of_frame_o) else $error("m-bit errors not ignored");
  ferf_read_a: assert property (
    ferf_det_i ##1 s_rd_st |=> wb_dat_o[`DFS_B_FERF])
    else $error("far-end failure not reported");
  aic_set_a: assert property (
    $rose(format_ident_flag) |-> $past(aic_run) == `DFS_AIC_RUN - 6'h01)
    else $error("format flag set early");
  aic_clr_a: assert property (
    format_ident_flag && a_if.hit |=> !format_ident_flag)
    else $error("format flag not cleared");
  febe_hold_a: assert property (
    mframe_en_i ##1 !mframe_en_i[*2] |-> far_end_block_err_code == $past(febe_i, 2))
    else $error("febe code not held");
  irq_level_a: assert property (
    |(int_stat & int_mask) |=> irq_o) else $error("interrupt not raised");

endmodule

// ==== dfs_win_if.sv ====
// event window link between the framer and an error window counter
`timescale 1ns/100ps
interface dfs_win_if;
  logic       ev;
  logic       err;
  logic       clr;
  logic [4:0] thr;
  logic       hit;
  modport host (output ev, output err, output clr, output thr, input hit);
  modport win  (input ev, input err, input clr, input thr, output hit);
endinterface

// ==== tb_dfs_rx_frame_sync.sv ====
// testbench for the ds3 frame sync and status register block
`timescale 1ns/100ps
module tb_dfs_rx_frame_sync;
  logic        clk_i = 1'b0;
  logic        rst_b = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] dat = 32'h0;
  logic [2:0]  det = 3'h0;
  logic [2:0]  ev_en = 3'h0;
  logic [2:0]  ev_err = 3'h0;
  logic        cand = 1'b0;
  logic        pok = 1'b0;
  logic        cerr = 1'b0;
  logic [31:0] rdat;
  logic        ack, irq, chk_en, gen_en, oof, refr, bit_en, bit_v, mf_en, aic;
  logic [2:0]  febe;
  int          bad_count = 0;
  int          tests_run = 0;
  int          rf_cnt = 0;
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) if (refr === 1'b1) rf_cnt++;
  dfs_liu_model i_liu (.clk_i(clk_i), .bit_en_o(bit_en), .bit_o(bit_v), .mf_en_o(mf_en),
    .aic_o(aic), .febe_o(febe));
  dfs_rx_frame_sync i_dut (.clk_i(clk_i), .rst_b_i(rst_b), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq), .rx_bit_en_i(bit_en), .rx_bit_i(bit_v),
    .ais_det_i(det[0]), .idle_det_i(det[1]), .ferf_det_i(det[2]), .frame_cand_i(cand),
    .parity_ok_i(pok), .fbit_en_i(ev_en[0]), .fbit_err_i(ev_err[0]), .mbit_en_i(ev_en[1]),
    .mbit_err_i(ev_err[1]), .pbit_en_i(ev_en[2]), .pbit_err_i(ev_err[2]),
    .cbit_err_i(cerr), .mframe_en_i(mf_en), .aic_bit_i(aic), .febe_i(febe),
    .pattern_checker_en_o(chk_en), .pattern_generator_en_o(gen_en),
    .out_of_frame_o(oof), .reframe_o(refr));
  task automatic end_of_test;
    if (bad_count == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // request held until the edge where ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d,
                    input logic [3:0] s, output logic [7:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat <= {24'h000000, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat[7:0];
    if (ack !== 1'b1) chk("ack", ack, 1);
    else chk("rdat hi", rdat[31:8], 24'h000000);
    cyc <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    wb(1'b1, a, d, 4'h1, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] q);
    wb(1'b0, a, 8'h00, 4'hF, q);
  endtask
  task automatic ev(input int k, input int n);
    repeat (n) begin
      @(posedge clk_i);
      ev_en[k] <= 1'b1;
      ev_err[k] <= 1'b1;
    end
    @(posedge clk_i);
    ev_en[k] <= 1'b0;
    ev_err[k] <= 1'b0;
    repeat (3) @(negedge clk_i);
  endtask
  task automatic lock(input logic p);
    @(posedge clk_i);
    cand <= 1'b1;
    pok <= p;
    @(posedge clk_i);
    cand <= 1'b0;
    @(negedge clk_i);
  endtask
  task automatic t_reg;
    logic [7:0] q;
    rd(8'h30, q);
    chk("tst rst", q, 8'h00);
    rd(8'h40, q);
    chk("cfg rst", q, 8'h10);
    rd(8'h44, q);
    chk("st rst", q, 8'h00);
    rd(8'h48, q);
    chk("imask rst", q, 8'h00);
    wr(8'h30, 8'h08);
    chk("chk on", {chk_en, gen_en}, 2'b10);
    wr(8'h30, 8'h04);
    chk("gen on", {chk_en, gen_en}, 2'b01);
    rd(8'h30, q);
    chk("tst rd", q & 8'h0C, 8'h04);
    wb(1'b1, 8'h30, 8'h08, 4'h0, q);
    chk("sel off", {chk_en, gen_en}, 2'b01);
    wr(8'h30, 8'h00);
    chk("both off", {chk_en, gen_en}, 2'b00);
    wr(8'h3C, 8'hFF);
    rd(8'h3C, q);
    chk("unmapped", q, 8'h00);
    wr(8'h40, 8'hFF);
    rd(8'h40, q);
    chk("cfg rw", q, 8'h17);
  endtask
  // k picks the f, m or p window; n errors in a row after lock
  task automatic t_loss(input logic [7:0] cfg, input int k, input int n, input logic e);
    logic [7:0] q;
    int r;
    wr(8'h40, cfg);
    lock(1'b1);
    chk("lock", oof, 0);
    r = rf_cnt;
    ev(k, n - 1);
    chk("below thr", oof, 0);
    ev(k, 1);
    chk("at thr", oof, e);
    chk("reframe", rf_cnt - r, e);
    rd(8'h40, q);
    chk("oof flag", q[4], e);
  endtask
  task automatic t_par;
    wr(8'h40, 8'h04);
    lock(1'b0);
    chk("par bad", oof, 1);
    lock(1'b1);
    chk("par ok", oof, 0);
  endtask
  task automatic t_flags;
    logic [7:0] q, q2, s;
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_i);
      det <= 3'h1 << i;
      repeat (2) @(negedge clk_i);
      rd(8'h40, q);
      rd(8'h44, s);
      rd(8'h40, q2);
      chk("ais", q[7], i == 0);
      chk("idle", q[5], i == 1);
      chk("ferf", s[4], i == 2);
      chk("reread", q2, q);
    end
    @(posedge clk_i);
    det <= 3'h0;
  endtask
  task automatic t_irq;
    logic [7:0] q;
    repeat (3) @(negedge clk_i);
    wr(8'h4C, 8'hFF);
    rd(8'h4C, q);
    chk("ist clr", q, 8'h00);
    @(posedge clk_i);
    cerr <= 1'b1;
    @(posedge clk_i);
    cerr <= 1'b0;
    rd(8'h4C, q);
    chk("ist cp", q, 8'h80);
    chk("irq masked", irq, 0);
    wr(8'h48, 8'h80);
    rd(8'h48, q);
    chk("imask", q, 8'h80);
    chk("irq on", irq, 1);
    wr(8'h4C, 8'h80);
    rd(8'h4C, q);
    chk("ist w1c", q, 8'h00);
    chk("irq off", irq, 0);
    wr(8'h48, 8'h00);
  endtask
  task automatic t_los;
    logic [7:0] q;
    i_liu.send_bits(175, 1'b0);
    rd(8'h40, q);
    chk("los early", q[6], 0);
    i_liu.send_bits(10, 1'b0);
    rd(8'h40, q);
    chk("los set", q[6], 1);
    rd(8'h4C, q);
    chk("los chg", q[6], 1);
    i_liu.send_bits(55, 1'b1);
    rd(8'h40, q);
    chk("los held", q[6], 1);
    i_liu.send_bits(10, 1'b1);
    rd(8'h40, q);
    chk("los clr", q[6], 0);
  endtask
  task automatic t_aic;
    logic [7:0] s;
    i_liu.send_frames(62, 1'b1, 3'h3);
    rd(8'h44, s);
    chk("aic 62", s[3:0], 4'h3);
    i_liu.send_frames(1, 1'b1, 3'h7);
    rd(8'h44, s);
    chk("aic 63", s[3:0], 4'hF);
    i_liu.send_frames(1, 1'b0, 3'h7);
    rd(8'h44, s);
    chk("aic one zero", s[3], 1);
    i_liu.send_frames(1, 1'b0, 3'h3);
    rd(8'h44, s);
    chk("aic two zeros", s[3:0], 4'h3);
  endtask
  // second reset in mid-run after bits were set
  task automatic t_rst;
    logic [7:0] q;
    wr(8'h30, 8'h0C);
    wr(8'h40, 8'h07);
    @(posedge clk_i);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b <= 1'b1;
    chk("en rst2", {chk_en, gen_en}, 2'b00);
    chk("irq rst2", irq, 0);
    rd(8'h40, q);
    chk("cfg rst2", q, 8'h10);
    rd(8'h44, q);
    chk("st rst2", q, 8'h00);
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test;
  end
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b <= 1'b1;
    t_reg;
    t_loss(8'h00, 0, 6, 1'b1);
    t_loss(8'h02, 0, 3, 1'b1);
    t_loss(8'h01, 1, 3, 1'b1);
    t_loss(8'h00, 1, 4, 1'b0);
    t_loss(8'h04, 2, 2, 1'b1);
    t_par;
    t_loss(8'h00, 2, 2, 1'b0);
    t_flags;
    t_irq;
    t_los;
    t_aic;
    t_rst;
    end_of_test;
  end
endmodule
